// ### verilog/sie_endec.sv
// sie_endec: serial infrared encoder/decoder with in-band programming
// assumes all inputs synchronous to sys_clk; ref_clk_in toggles below sys_clk/2
//
// Functional notes
// - zero bits shortened to fixed or 3/16 pulse
// - width select one fixed, zero 3/16
// - at 115.2k both widths are equal
// - control byte LSB first after start bit
// - user outputs follow control bits five, six
// - four-bit code selects thirteen bit rates
// - rates derived from reference clock, scale with it
// - select low means encode host transmit data
// - zero bit sends pulse, one sends none
// - transmit lamp follows transmitted data
// - received pulse gives one zero bit time
// - output independent of received pulse length
// - receive lamp follows decoded receive data
// - select high: character is control word
// - new rate applies when select falls
// - reset starts at 9600 bit/s
`timescale 1ns/1ps
module sie_endec (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // reference timing
    input  wire logic ref_clk_in,
    // host side
    input  wire logic rate_program_select,
    input  wire logic host_tx_in,
    output logic      host_rx_out,
    // transceiver side
    input  wire logic optical_rx_in,
    output logic      optical_tx_out,
    // indicators and user outputs
    output logic      tx_activity_lamp,
    output logic      rx_activity_lamp,
    output logic      user_output_one,
    output logic      user_output_two
);

    logic                     ref_q,   ref_d;
    logic [7:0]               pre_q,   pre_d;
    logic [3:0]               rate_q,  rate_d;
    logic [3:0]               pend_q,  pend_d;
    logic                     pw_q,    pw_d;
    logic                     u1_q,    u1_d;
    logic                     u2_q,    u2_d;
    logic                     sel_q,   sel_d;
    logic                     txp_q,   txp_d;
    logic [3:0]               txs_q,   txs_d;
    logic [9:0]               pcnt_q,  pcnt_d;
    logic                     irt_q,   irt_d;
    logic                     rxp_q,   rxp_d;
    logic [4:0]               rxc_q,   rxc_d;
    logic                     nrz_q,   nrz_d;
    logic                     txl_q,   txl_d;
    sie_pkg::sie_prog_state_t st_q,    st_d;
    logic [3:0]               us_q,    us_d;
    logic [2:0]               ub_q,    ub_d;
    logic [7:0]               sh_q,    sh_d;

    logic                     ref_tick;
    logic                     six_tick;
    logic [7:0]               div;
    logic                     tx_fall;
    logic                     pulse_go;
    logic [9:0]               width;
    sie_pkg::sie_ctrl_t       ctrl;

    always_comb begin
        ref_d  = ref_clk_in;
        sel_d  = rate_program_select;
        txp_d  = host_tx_in;
        rxp_d  = optical_rx_in;
        rate_d = rate_q;
        pend_d = pend_q;
        pw_d   = pw_q;
        u1_d   = u1_q;
        u2_d   = u2_q;
        st_d   = st_q;
        us_d   = us_q;
        ub_d   = ub_q;
        sh_d   = sh_q;
        txs_d  = txs_q;
        rxc_d  = rxc_q;
        ctrl   = sh_q;

        // sixteenth-bit tick from reference edges, scales with reference
        ref_tick = ref_clk_in & ~ref_q;
        div      = sie_pkg::sie_rate_div(rate_q);
        // catches up at once when a faster rate is switched in
        six_tick = ref_tick && (pre_q >= div - 8'h01);
        pre_d    = pre_q;
        if (ref_tick) begin
            pre_d = six_tick ? 8'h00 : pre_q + 8'h01;
        end

        // encoder: pulse at each zero bit start, data mode only
        tx_fall  = txp_q & ~host_tx_in;
        pulse_go = 1'b0;
        if (!rate_program_select) begin
            if (tx_fall) begin
                txs_d    = 4'h0;
                pulse_go = 1'b1;
            end else if (!host_tx_in && six_tick) begin
                txs_d    = txs_q + 4'h1;
                pulse_go = (txs_q == sie_pkg::SIXT_LAST);
            end
        end
        // width: fixed ticks or three sixteenths
        width = pw_q ? sie_pkg::PULSE_FIXED
                     : 10'({2'h0, div} * {8'h00, sie_pkg::PULSE_SIXTHS});
        pcnt_d = pcnt_q;
        if (rate_program_select) begin
            pcnt_d = 10'h000;
        end else if (pulse_go) begin
            pcnt_d = width;
        end else if (ref_tick && pcnt_q != 10'h000) begin
            pcnt_d = pcnt_q - 10'h001;
        end
        irt_d = (pcnt_d != 10'h000);
        txl_d = ~host_tx_in;

        // decoder: rising edge starts one full bit of zero
        if (optical_rx_in && !rxp_q) begin
            rxc_d = sie_pkg::SIXT_PER_BIT;
        end else if (six_tick && rxc_q != 5'h00) begin
            rxc_d = rxc_q - 5'h01;
        end
        nrz_d = (rxc_d == 5'h00);

        // programming receiver, 8N1 from host
        unique case (st_q)
            sie_pkg::SIE_IDLE: begin
                if (tx_fall) begin
                    st_d = sie_pkg::SIE_START;
                    us_d = 4'h0;
                end
            end
            sie_pkg::SIE_START: begin
                if (six_tick) begin
                    us_d = us_q + 4'h1;
                    if (us_q == sie_pkg::SIXT_MID) begin
                        st_d = host_tx_in ? sie_pkg::SIE_IDLE : sie_pkg::SIE_DATA;
                        us_d = 4'h0;
                        ub_d = 3'h0;
                    end
                end
            end
            sie_pkg::SIE_DATA: begin
                if (six_tick) begin
                    us_d = us_q + 4'h1;
                    if (us_q == sie_pkg::SIXT_LAST) begin
                        sh_d = {host_tx_in, sh_q[7:1]};
                        ub_d = ub_q + 3'h1;
                        if (ub_q == sie_pkg::BITS_LAST) begin
                            st_d = sie_pkg::SIE_STOP;
                        end
                    end
                end
            end
            sie_pkg::SIE_STOP: begin
                if (six_tick) begin
                    us_d = us_q + 4'h1;
                    if (us_q == sie_pkg::SIXT_LAST) begin
                        st_d = sie_pkg::SIE_IDLE;
                        if (host_tx_in) begin
                            pw_d = ctrl.pulse_width_select;
                            u1_d = ctrl.user_output_one;
                            u2_d = ctrl.user_output_two;
                            if (sie_pkg::sie_rate_ok(ctrl.rate_code)) begin
                                pend_d = ctrl.rate_code;
                            end
                        end
                    end
                end
            end
        endcase
        if (!rate_program_select) begin
            st_d = sie_pkg::SIE_IDLE;
        end
        // rate switches on select falling
        if (sel_q && !rate_program_select) begin
            rate_d = pend_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ref_q  <= 1'b0;
            pre_q  <= 8'h00;
            rate_q <= sie_pkg::RATE_RST;
            pend_q <= sie_pkg::RATE_RST;
            pw_q   <= sie_pkg::PW_RST;
            u1_q   <= sie_pkg::USER_RST;
            u2_q   <= sie_pkg::USER_RST;
            sel_q  <= 1'b0;
            txp_q  <= 1'b1;
            txs_q  <= 4'h0;
            pcnt_q <= 10'h000;
            irt_q  <= 1'b0;
            rxp_q  <= 1'b0;
            rxc_q  <= 5'h00;
            nrz_q  <= 1'b1;
            txl_q  <= 1'b0;
            st_q   <= sie_pkg::SIE_IDLE;
            us_q   <= 4'h0;
            ub_q   <= 3'h0;
            sh_q   <= 8'h00;
        end else begin
            ref_q  <= ref_d;
            pre_q  <= pre_d;
            rate_q <= rate_d;
            pend_q <= pend_d;
            pw_q   <= pw_d;
            u1_q   <= u1_d;
            u2_q   <= u2_d;
            sel_q  <= sel_d;
            txp_q  <= txp_d;
            txs_q  <= txs_d;
            pcnt_q <= pcnt_d;
            irt_q  <= irt_d;
            rxp_q  <= rxp_d;
            rxc_q  <= rxc_d;
            nrz_q  <= nrz_d;
            txl_q  <= txl_d;
            st_q   <= st_d;
            us_q   <= us_d;
            ub_q   <= ub_d;
            sh_q   <= sh_d;
        end
    end

    assign optical_tx_out   = irt_q;
    assign host_rx_out      = nrz_q;
    assign tx_activity_lamp = txl_q;
    assign rx_activity_lamp = ~nrz_q;
    assign user_output_one  = u1_q;
    assign user_output_two  = u2_q;

endmodule

// ### verilog/sie_pkg.sv
// sie_pkg: constants, control-byte layout, state codes and rate decode
// assumes a 3.6864 MHz reference sampled on a 10 MHz system clock
package sie_pkg;

    // clocks
    localparam int unsigned SYS_CLK_HZ      = 10_000_000;
    localparam int unsigned REF_HZ          = 3_686_400;
    // fixed pulse, printed as 1.627 us, rounded to reference ticks
    localparam int unsigned PULSE_FIXED_NS  = 1627;
    localparam int unsigned PULSE_FIXED_REF =
        (PULSE_FIXED_NS * (REF_HZ / 100) + 5_000_000) / 10_000_000;
    localparam logic [9:0]  PULSE_FIXED     = PULSE_FIXED_REF[9:0];
    // three sixteenths of a bit
    localparam logic [1:0]  PULSE_SIXTHS    = 2'h3;
    localparam logic [3:0]  SIXT_LAST       = 4'hF;
    localparam logic [3:0]  SIXT_MID        = 4'h7;
    localparam logic [4:0]  SIXT_PER_BIT    = 5'h10;
    localparam logic [2:0]  BITS_LAST       = 3'h7;

    // control byte layout and reset values
    localparam logic [3:0]  RATE_RST        = 4'h6;
    localparam logic [3:0]  RATE_MAX        = 4'hC;
    localparam logic        PW_RST          = 1'h1;
    localparam logic        USER_RST        = 1'h0;

    typedef struct packed {
        logic       spare;
        logic       user_output_two;
        logic       user_output_one;
        logic       pulse_width_select;
        logic [3:0] rate_code;
    } sie_ctrl_t;

    typedef enum logic [1:0] {
        SIE_IDLE  = 2'h0,
        SIE_START = 2'h1,
        SIE_DATA  = 2'h3,
        SIE_STOP  = 2'h2
    } sie_prog_state_t;

    // reference ticks per sixteenth of a bit
    function automatic logic [7:0] sie_rate_div(input logic [3:0] code);
        logic [7:0] d;
        d = 8'h18;
        unique case (code)
            4'h0: d = 8'h02;
            4'h1: d = 8'h04;
            4'h2: d = 8'h06;
            4'h3: d = 8'h0C;
            4'h4: d = 8'h10;
            4'h5: d = 8'h12;
            4'h6: d = 8'h18;
            4'h7: d = 8'h20;
            4'h8: d = 8'h30;
            4'h9: d = 8'h40;
            4'hA: d = 8'h60;
            4'hB: d = 8'h80;
            4'hC: d = 8'hC0;
            default: d = 8'h18;
        endcase
        return d;
    endfunction

    function automatic logic sie_rate_ok(input logic [3:0] code);
        return code <= RATE_MAX;
    endfunction

endpackage

// ### sim/sie_endec_assertions.sv
// sie_endec_assertions: port checks of the endec
// assumes a bind onto sie_endec from the bench top
`timescale 1ns/1ps
module sie_endec_assertions (
    // clock, reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // inputs
    input wire logic rate_program_select,
    input wire logic host_tx_in,
    input wire logic optical_rx_in,
    // outputs
    input wire logic host_rx_out,
    input wire logic optical_tx_out,
    input wire logic tx_activity_lamp,
    input wire logic rx_activity_lamp,
    input wire logic user_output_one,
    input wire logic user_output_two
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    a_reset_values: assert property (disable iff (1'b0)
        sys_rst |=> host_rx_out && !optical_tx_out && !user_output_one
        && !user_output_two && !tx_activity_lamp)
        else $error("reset values");
    a_enc_answer: assert property (
        !rate_program_select && $fell(host_tx_in) |=> optical_tx_out)
        else $error("no tx pulse");
    a_prog_quiet: assert property (
        rate_program_select && $past(rate_program_select) |-> !optical_tx_out)
        else $error("pulse in program mode");
    a_dec_answer: assert property (
        $rose(optical_rx_in) |=> !host_rx_out)
        else $error("no rx zero");
    a_dec_stretch: assert property (
        $fell(optical_rx_in) && !host_rx_out |=> !host_rx_out [*8])
        else $error("rx zero cut short");
    a_rx_lamp: assert property (
        rx_activity_lamp == !host_rx_out)
        else $error("rx lamp");
    a_tx_lamp: assert property (
        !$past(sys_rst) |-> tx_activity_lamp == !$past(host_tx_in))
        else $error("tx lamp");
    a_user_hold: assert property (
        !rate_program_select && !$past(rate_program_select)
        |-> $stable({user_output_one, user_output_two}))
        else $error("user outputs moved");
endmodule

// ### sim/sie_far_end.sv
// sie_far_end: host uart, transceiver and reference model
// assumes one sys_clk; lines change at its rising edge
`timescale 1ns/1ps
module sie_far_end (
    // clock
    input  wire logic sys_clk,
    // lines into the endec
    output logic      ref_clk_in,
    output logic      host_tx_in,
    output logic      optical_rx_in,
    // reference rising edge seen
    output logic      tick
);
    int unsigned acc_q   = 0;
    logic        ref_p_q = 1'b0;
    assign ref_clk_in = acc_q < 100000;
    assign tick       = ref_clk_in & ~ref_p_q;
    initial begin
        host_tx_in    = 1'b1;
        optical_rx_in = 1'b0;
    end
    // phase accumulator, 3.6864 MHz
    always_ff @(posedge sys_clk) begin
        acc_q   <= (acc_q + 73728) % 200000;
        ref_p_q <= ref_clk_in;
    end
    task automatic wait_ticks(input int n);
        repeat (n) @(posedge sys_clk iff tick);
    endtask
    // start bit, lsb first, one stop
    task automatic send_byte(input logic [7:0] b, input int bt);
        for (int i = 0; i < 10; i++) begin
            host_tx_in <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[3'(i - 1)];
            wait_ticks(bt);
        end
    endtask
    task automatic pulse_rx(input int len);
        @(posedge sys_clk);
        optical_rx_in <= 1'b1;
        repeat (len) @(posedge sys_clk);
        optical_rx_in <= 1'b0;
    endtask
endmodule

// ### sim/sie_endec_tb_top.sv
// sie_endec_tb_top: random programming, encode and decode runs
// assumes sie_far_end drives reference, host and optical lines
`timescale 1ns/1ps
module sie_endec_tb_top;
    logic               sys_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               rate_program_select = 1'b0;
    logic               ref_clk_in, host_tx_in, optical_rx_in, tick;
    logic               host_rx_out, optical_tx_out, user_output_one, user_output_two;
    logic               tx_activity_lamp, rx_activity_lamp;
    logic               pw = 1'b1;
    int                 failures = 0;
    int                 check_count = 0;
    int                 cycles = 0;
    int                 cur = 6;
    int                 n;
    int                 dv[13] = '{2, 4, 6, 12, 16, 18, 24, 32, 48, 64, 96, 128, 192};
    sie_pkg::sie_ctrl_t c;
    sie_endec dut (.sys_clk, .sys_rst, .ref_clk_in, .rate_program_select, .host_tx_in,
        .host_rx_out, .optical_rx_in, .optical_tx_out, .tx_activity_lamp,
        .rx_activity_lamp, .user_output_one, .user_output_two);
    sie_far_end far (.sys_clk, .ref_clk_in, .host_tx_in, .optical_rx_in, .tick);
    initial forever #50 sys_clk = ~sys_clk;
    task automatic wrap_up;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic check_bit(input string nm, input logic e, input logic s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s exp %b got %b", nm, e, s);
        end
    endtask
    task automatic check_rng(input string nm, input int lo, input int hi, input int s);
        check_count++;
        if (s < lo || s > hi) begin
            failures++;
            $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, s);
        end
    endtask
    // reference ticks while the output is active
    task automatic span(input logic tx, output int k);
        int g;
        k = 0;
        for (g = 0; g < 400 && (tx ? optical_tx_out : !host_rx_out) !== 1'b1; g++) begin
            @(negedge sys_clk);
        end
        for (g = 0; g < 20000 && (tx ? optical_tx_out : !host_rx_out) === 1'b1; g++) begin
            @(negedge sys_clk);
            k += int'(tick);
        end
    endtask
    task automatic decode(input string nm);
        fork
            far.pulse_rx(1 + $urandom % 40);
            span(1'b0, n);
        join
        check_rng(nm, 15 * dv[cur] - 2, 16 * dv[cur] + 2, n);
        check_bit("rx lamp", 1'b0, rx_activity_lamp);
        far.wait_ticks(4);
    endtask
    task automatic encode;
        @(posedge sys_clk);
        far.host_tx_in <= 1'b0;
        span(1'b1, n);
        check_bit("tx lamp", 1'b1, tx_activity_lamp);
        @(posedge sys_clk);
        far.host_tx_in <= 1'b1;
        check_rng("tx pulse", (pw ? 6 : 3 * dv[cur]) - 1, (pw ? 6 : 3 * dv[cur]) + 1, n);
        far.wait_ticks(16 * dv[cur]);
    endtask
    initial begin
        void'($urandom(32'hEEBB0F27));
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        check_bit("rx idle", 1'b1, host_rx_out);
        encode();
        for (int i = 0; i < 6; i++) begin
            c = sie_pkg::sie_ctrl_t'(8'($urandom));
            c.rate_code = (i == 0) ? 4'h0 : (i == 1) ? 4'hD : (i == 5) ? 4'hC
                        : c.rate_code % 4'h6;
            c.pulse_width_select = (i < 2) ? i[0] : (i != 3);
            @(posedge sys_clk);
            rate_program_select <= 1'b1;
            far.wait_ticks(16);
            far.send_byte(c, 16 * dv[cur]);
            @(negedge sys_clk);
            check_bit("user one", c.user_output_one, user_output_one);
            check_bit("user two", c.user_output_two, user_output_two);
            decode("rx old rate");
            @(posedge sys_clk);
            rate_program_select <= 1'b0;
            repeat (2) @(posedge sys_clk);
            pw = c.pulse_width_select;
            if (c.rate_code <= 4'hC) begin
                cur = int'(c.rate_code);
            end
            decode("rx new rate");
            encode();
        end
        wrap_up();
    end
endmodule
bind sie_endec sie_endec_assertions chk (.sys_clk, .sys_rst, .rate_program_select,
    .host_tx_in, .optical_rx_in, .host_rx_out, .optical_tx_out, .tx_activity_lamp,
    .rx_activity_lamp, .user_output_one, .user_output_two);
